/* File: logic/rdc_pkg.sv */
// shared constants and carriers for the rs485 uart with driver direction control
package rdc_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [2:0] OFF_HOLD    = 3'h0;
	localparam logic [2:0] OFF_IER     = 3'h1;
	localparam logic [2:0] OFF_IIR     = 3'h2;
	localparam logic [2:0] OFF_LCR     = 3'h3;
	localparam logic [2:0] OFF_MCR     = 3'h4;
	localparam logic [2:0] OFF_LSR     = 3'h5;
	localparam logic [2:0] OFF_MSR     = 3'h6;
	localparam logic [2:0] OFF_CONFIRM = 3'h7;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int LCR_DIVISOR_LATCH_SELECT     = 7;
	localparam int LCR_STOP     = 2;
	localparam int MCR_DTR      = 0;
	localparam int MCR_DIR      = 1;
	localparam int MCR_AUTO     = 2;
	localparam int MCR_422      = 3;
	localparam int MCR_LOOP     = 4;
	localparam int IER_RX_AVAIL = 0;

	// ------------------------------------------------------------
	// values after reset and fixed answers
	// ------------------------------------------------------------
	localparam logic [7:0] LCR_RST     = 8'h03;
	localparam logic [7:0] MCR_RST     = 8'h00;
	localparam logic [7:0] DIV_LO_RST  = 8'h0C;
	localparam logic [7:0] DIV_HI_RST  = 8'h00;
	localparam logic [7:0] MCR_MASK    = 8'h1F;
	localparam logic [7:0] IIR_NONE    = 8'h01;
	localparam logic [7:0] IIR_RX_DATA = 8'h04;
	localparam logic [7:0] MSR_VALUE   = 8'h00;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam real        REF_MHZ     = 1.8432;
	localparam logic [3:0] OVS_LAST    = 4'hF;
	localparam logic [3:0] OVS_MID     = 4'h7;
	localparam logic [7:0] OVS_FACTOR  = 8'h10;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} rdc_bus_req_t;

	typedef struct packed {
		logic txd;
		logic drv_en;
		logic dtr;
		logic mode_422;
	} rdc_line_t;

endpackage : rdc_pkg

/* File: logic/rdc_baud.sv */
// sixteen-times oversampling tick from the reference clock edges
module rdc_baud import rdc_pkg::*; (
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_ref_rise,
	input  wire logic [15:0] i_divisor,
	output logic             o_tick16
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} rdc_baud_st_t;

	rdc_baud_st_t st_r;
	rdc_baud_st_t st_nxt;

	// a divisor of zero wraps and acts as 65536; a smaller divisor takes hold at once
	always_comb begin
		st_nxt      = st_r;
		st_nxt.tick = 1'b0;
		if (i_ref_rise) begin
			if (st_r.cnt >= i_divisor - 16'h0001) begin
				st_nxt.cnt  = 16'h0000;
				st_nxt.tick = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_tick16 = st_r.tick;
endmodule : rdc_baud

/* File: logic/rdc_rx.sv */
// serial receiver, mid-bit sampling on the oversampling tick
module rdc_rx import rdc_pkg::*; (
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_tick16,
	input  wire logic       i_rxd,
	input  wire logic       i_halt,
	input  wire logic [1:0] i_len_code,
	output logic            o_valid,
	output logic [7:0]      o_data
);
	typedef struct packed {
		logic       active;
		logic [3:0] ovs;
		logic [3:0] bit_idx;
		logic [7:0] data;
		logic       valid;
	} rdc_rx_st_t;

	rdc_rx_st_t st_r;
	rdc_rx_st_t st_nxt;
	logic [3:0] last_idx;

	// index 0 start, 1..len data, len+1 stop
	assign last_idx = 4'(i_len_code) + 4'h6;

	always_comb begin
		st_nxt       = st_r;
		st_nxt.valid = 1'b0;
		if (i_halt) begin
			st_nxt.active = 1'b0;
		end else if (i_tick16) begin
			if (!st_r.active) begin
				if (!i_rxd) begin
					st_nxt.active  = 1'b1;
					st_nxt.ovs     = 4'h0;
					st_nxt.bit_idx = 4'h0;
				end
			end else begin
				st_nxt.ovs = st_r.ovs + 4'h1;
				if (st_r.ovs == OVS_MID) begin
					if (st_r.bit_idx == 4'h0 && i_rxd) begin
						st_nxt.active = 1'b0;
					end else if (st_r.bit_idx == last_idx) begin
						st_nxt.active = 1'b0;
						st_nxt.valid  = i_rxd;
					end else if (st_r.bit_idx != 4'h0) begin
						st_nxt.data = {i_rxd, st_r.data[7:1]};
					end
				end
				if (st_r.ovs == OVS_LAST) begin
					st_nxt.bit_idx = st_r.bit_idx + 4'h1;
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// short characters arrive in the top bits; align them to bit 0
	assign o_valid = st_r.valid;
	assign o_data  = st_r.data >> (2'h3 - i_len_code);
endmodule : rdc_rx

/* File: logic/rdc_uart.sv */
// byte register uart with manual or automatic rs485 driver direction
// ------------------------------------------------------------
// Notes on behaviour
// - each register is one byte at its own offset, byte accesses only.
// - line control bit 7 swaps offsets 0 and 1 to the divisor.
// - with that bit set, offset 0 writes divisor low, offset 1 high.
// - bit timing derives from the 1.8432 MHz reference through the divisor.
// - divisor 1, 2, 12, 96 give 115200, 57600, 9600, 1200 baud.
// - line control bits 1:0 hold character length minus five.
// - line control bit 2 clear sends one stop bit, set sends two.
// - modem control bit 0 drives the terminal ready output.
// - manual mode, modem control bit 1 high enables the driver.
// - modem control bit 2 high makes direction follow the transmit buffer.
// - bit 3 selects rs422; writing it one clears bit 2.
// - bit 4 enables internal loopback; bits 5 to 7 unused.
// - line status bit 0 high while a received byte waits.
// - line status bit 5 high while the holding register is empty.
// - offset 2 reads 0x04 with data waiting and interrupt enable bit 0 set, else 0x01.
// - automatic driver stays on one character time after the last byte.
// - rs485 shares one pair, so reception is blanked while driving.
// ------------------------------------------------------------
module rdc_uart import rdc_pkg::*; (
	input  wire logic         i_clk,
	input  wire logic         i_rst_b,
	input  wire rdc_bus_req_t i_bus,
	output logic [7:0]        o_rdata,
	input  wire logic         i_ref_clk,
	input  wire logic         i_rxd,
	output rdc_line_t         o_line
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  lcr;
		logic [7:0]  mcr;
		logic [7:0]  ier;
		logic [7:0]  confirm;
		logic [7:0]  div_lo;
		logic [7:0]  div_hi;
		logic [7:0]  rbr;
		logic        rx_full;
		logic [7:0]  thr;
		logic        thr_full;
		logic        busy;
		logic [10:0] shift;
		logic [3:0]  bits_left;
		logic [3:0]  ovs;
		logic [7:0]  hold_cnt;
		logic        drv;
		logic [7:0]  rdata;
		logic [1:0]  rx_sync;
		logic [1:0]  ref_sync;
		logic        ref_prev;
	} rdc_core_t;

	rdc_core_t  st_r;
	rdc_core_t  st_nxt;
	logic       tick16;
	logic       rx_valid;
	logic [7:0] rx_data;
	logic       divisor_latch_select;
	logic       ref_rise;
	logic       rx_in;
	logic [3:0] frame_bits;
	logic [7:0] len_mask;
	logic [7:0] lsr;
	logic [7:0] iir;
	logic       auto_on;
	logic       wr_hold;
	logic       rd_hold;

	assign divisor_latch_select       = st_r.lcr[LCR_DIVISOR_LATCH_SELECT];
	assign ref_rise   = st_r.ref_sync[1] & ~st_r.ref_prev;
	assign frame_bits = 4'(st_r.lcr[1:0]) + 4'h7 + 4'(st_r.lcr[LCR_STOP]);
	assign len_mask   = 8'hFF >> (2'h3 - st_r.lcr[1:0]);
	assign wr_hold    = i_bus.wr && i_bus.addr == OFF_HOLD && !divisor_latch_select;
	assign rd_hold    = i_bus.rd && i_bus.addr == OFF_HOLD && !divisor_latch_select;
	assign lsr        = {1'b0, !st_r.thr_full && !st_r.busy, !st_r.thr_full,
		4'h0, st_r.rx_full};
	assign iir        = (st_r.rx_full && st_r.ier[IER_RX_AVAIL]) ? IIR_RX_DATA : IIR_NONE;
	assign auto_on    = st_r.busy || st_r.thr_full || st_r.hold_cnt != 8'h00;

	// loopback feeds the transmitter back; rs485 blanks our own echo
	always_comb begin
		if (st_r.mcr[MCR_LOOP]) begin
			rx_in = st_r.shift[0];
		end else if (!st_r.mcr[MCR_422] && st_r.drv) begin
			rx_in = 1'b1;
		end else begin
			rx_in = st_r.rx_sync[1];
		end
	end

	// ------------------------------------------------------------
	// baud generator and receiver
	// ------------------------------------------------------------
	rdc_baud u_baud (
		.i_clk      (i_clk),
		.i_rst_b    (i_rst_b),
		.i_ref_rise (ref_rise),
		.i_divisor  ({st_r.div_hi, st_r.div_lo}),
		.o_tick16   (tick16)
	);

	rdc_rx u_rx (
		.i_clk      (i_clk),
		.i_rst_b    (i_rst_b),
		.i_tick16   (tick16),
		.i_rxd      (rx_in),
		.i_halt     (divisor_latch_select),
		.i_len_code (st_r.lcr[1:0]),
		.o_valid    (rx_valid),
		.o_data     (rx_data)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt          = st_r;
		st_nxt.rx_sync  = {st_r.rx_sync[0], i_rxd};
		st_nxt.ref_sync = {st_r.ref_sync[0], i_ref_clk};
		st_nxt.ref_prev = st_r.ref_sync[1];

		// register writes, one byte each
		if (i_bus.wr) begin
			unique case (i_bus.addr)
				OFF_HOLD: begin
					if (divisor_latch_select) begin
						st_nxt.div_lo = i_bus.wdata;
					end else begin
						st_nxt.thr      = i_bus.wdata;
						st_nxt.thr_full = 1'b1;
					end
				end
				OFF_IER: begin
					if (divisor_latch_select) begin
						st_nxt.div_hi = i_bus.wdata;
					end else begin
						st_nxt.ier = i_bus.wdata;
					end
				end
				OFF_LCR: st_nxt.lcr = i_bus.wdata;
				OFF_MCR: begin
					st_nxt.mcr = i_bus.wdata & MCR_MASK;
					if (i_bus.wdata[MCR_422]) begin
						st_nxt.mcr[MCR_AUTO] = 1'b0;
					end
				end
				OFF_CONFIRM: st_nxt.confirm = i_bus.wdata;
				OFF_IIR, OFF_LSR, OFF_MSR: ;
			endcase
		end

		// register reads; offset 0 pops the receive byte unless divisor select is set
		if (i_bus.rd) begin
			unique case (i_bus.addr)
				OFF_HOLD:    st_nxt.rdata = divisor_latch_select ? st_r.div_lo : st_r.rbr;
				OFF_IER:     st_nxt.rdata = divisor_latch_select ? st_r.div_hi : 8'h00;
				OFF_IIR:     st_nxt.rdata = iir;
				OFF_LCR:     st_nxt.rdata = st_r.lcr;
				OFF_MCR:     st_nxt.rdata = st_r.mcr;
				OFF_LSR:     st_nxt.rdata = lsr;
				OFF_MSR:     st_nxt.rdata = MSR_VALUE;
				OFF_CONFIRM: st_nxt.rdata = st_r.confirm;
			endcase
		end
		if (rd_hold) begin
			st_nxt.rx_full = 1'b0;
		end
		// a byte landing in the same cycle as the pop is kept
		if (rx_valid) begin
			st_nxt.rbr     = rx_data;
			st_nxt.rx_full = 1'b1;
		end

		// transmitter: start, data, one or two stop bits
		if (!st_r.busy && st_r.thr_full && !divisor_latch_select && !wr_hold) begin
			st_nxt.busy      = 1'b1;
			st_nxt.thr_full  = 1'b0;
			st_nxt.shift     = {2'b11, st_r.thr | ~len_mask, 1'b0};
			st_nxt.bits_left = frame_bits;
			st_nxt.ovs       = 4'h0;
		end else if (st_r.busy && tick16) begin
			st_nxt.ovs = st_r.ovs + 4'h1;
			if (st_r.ovs == OVS_LAST) begin
				st_nxt.shift     = {1'b1, st_r.shift[10:1]};
				st_nxt.bits_left = st_r.bits_left - 4'h1;
				if (st_r.bits_left == 4'h1) begin
					st_nxt.busy = 1'b0;
				end
			end
		end

		// driver tail: one whole character of ticks after the shifter drains
		if (st_r.busy || st_r.thr_full) begin
			st_nxt.hold_cnt = 8'(frame_bits) * OVS_FACTOR;
		end else if (tick16 && st_r.hold_cnt != 8'h00) begin
			st_nxt.hold_cnt = st_r.hold_cnt - 8'h01;
		end

		// direction select; rs422 has its own pair so the driver stays on
		if (st_nxt.mcr[MCR_LOOP]) begin
			st_nxt.drv = 1'b0;
		end else if (st_nxt.mcr[MCR_422]) begin
			st_nxt.drv = 1'b1;
		end else if (st_nxt.mcr[MCR_AUTO]) begin
			st_nxt.drv = st_nxt.busy || st_nxt.thr_full || st_nxt.hold_cnt != 8'h00;
		end else begin
			st_nxt.drv = st_nxt.mcr[MCR_DIR];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r        <= '0;
			st_r.lcr    <= LCR_RST;
			st_r.mcr    <= MCR_RST;
			st_r.div_lo <= DIV_LO_RST;
			st_r.div_hi <= DIV_HI_RST;
			st_r.shift  <= '1;
			st_r.rx_sync <= '1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// loopback keeps the line idle so self test disturbs nobody
	assign o_rdata         = st_r.rdata;
	assign o_line.txd      = st_r.shift[0] | st_r.mcr[MCR_LOOP];
	assign o_line.drv_en   = st_r.drv;
	assign o_line.dtr      = st_r.mcr[MCR_DTR];
	assign o_line.mode_422 = st_r.mcr[MCR_422];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	a_div_low_load: assert property (
		(i_bus.wr && i_bus.addr == OFF_HOLD && divisor_latch_select) |=> st_r.div_lo == $past(i_bus.wdata))
		else $error("divisor low byte not loaded");
	a_div_high_load: assert property (
		(i_bus.wr && i_bus.addr == OFF_IER && divisor_latch_select) |=> st_r.div_hi == $past(i_bus.wdata))
		else $error("divisor high byte not loaded");
	a_div_read_swap: assert property (
		(i_bus.rd && i_bus.addr == OFF_HOLD && divisor_latch_select && !i_bus.wr) |=> o_rdata == $past(st_r.div_lo))
		else $error("offset 0 read ignores divisor select");
	a_rs422_clears_auto: assert property (
		(i_bus.wr && i_bus.addr == OFF_MCR && i_bus.wdata[MCR_422])
		|=> !st_r.mcr[MCR_AUTO] && o_line.mode_422)
		else $error("rs422 write left automatic direction set");
	a_manual_dir_follow: assert property (
		(i_bus.wr && i_bus.addr == OFF_MCR && i_bus.wdata[4:2] == 3'b000)
		|=> o_line.drv_en == $past(i_bus.wdata[MCR_DIR]))
		else $error("manual driver direction wrong");
	a_dtr_follow: assert property (
		(i_bus.wr && i_bus.addr == OFF_MCR) |=> o_line.dtr == $past(i_bus.wdata[MCR_DTR]))
		else $error("terminal ready does not follow bit 0");
	a_auto_drive_on: assert property (
		(wr_hold && st_r.mcr[MCR_AUTO] && !st_r.mcr[MCR_422] && !st_r.mcr[MCR_LOOP]
		&& !(i_bus.addr == OFF_MCR && i_bus.wr)) |=> o_line.drv_en)
		else $error("automatic driver not on with data queued");
	a_auto_tail_hold: assert property (
		($fell(st_r.busy) && !st_r.thr_full && st_r.mcr[MCR_AUTO]
		&& !st_r.mcr[MCR_422] && !st_r.mcr[MCR_LOOP] && !i_bus.wr) |-> o_line.drv_en)
		else $error("driver dropped at end of character");
	a_lsr_ready_bit: assert property (
		(i_bus.rd && i_bus.addr == OFF_LSR) |=> o_rdata[0] == $past(st_r.rx_full))
		else $error("data ready bit wrong");
	a_holding_busy: assert property (
		wr_hold |=> (st_r.thr_full || st_r.busy) && !lsr[6])
		else $error("holding empty after a write");
	a_iir_idle: assert property (
		(i_bus.rd && i_bus.addr == OFF_IIR && !st_r.rx_full) |=> o_rdata == IIR_NONE)
		else $error("identification not idle");
	a_echo_blank: assert property (
		(st_r.drv && !st_r.mcr[MCR_422] && !st_r.mcr[MCR_LOOP] && !u_rx.st_r.active)
		|=> !u_rx.st_r.active)
		else $error("own transmission reaches the receiver");
	a_auto_level: assert property (
		(st_r.mcr[MCR_AUTO] && !st_r.mcr[MCR_422] && !st_r.mcr[MCR_LOOP])
		|-> o_line.drv_en == auto_on)
		else $error("automatic driver does not follow the transmit buffer");
	a_manual_hold: assert property (
		(!st_r.mcr[MCR_AUTO] && !st_r.mcr[MCR_422] && !st_r.mcr[MCR_LOOP]
		&& !(i_bus.wr && i_bus.addr == OFF_MCR))
		|=> o_line.drv_en == $past(st_r.mcr[MCR_DIR]))
		else $error("manual driver moved without a control write");
	a_rs422_drive: assert property (
		(st_r.mcr[MCR_422] && !st_r.mcr[MCR_LOOP]) |-> o_line.drv_en)
		else $error("rs422 driver not on");
	a_loop_line_idle: assert property (
		st_r.mcr[MCR_LOOP] |-> o_line.txd && !o_line.drv_en)
		else $error("loopback disturbs the line");
	a_mcr_upper_zero: assert property (
		(i_bus.wr && i_bus.addr == OFF_MCR) |=> st_r.mcr[7:5] == 3'h0)
		else $error("unused control bits kept");
	a_tick_on_ref: assert property (
		tick16 |-> $past(ref_rise))
		else $error("oversampling tick without a reference edge");
	a_tx_launch: assert property (
		(!st_r.busy && st_r.thr_full && !divisor_latch_select && !st_r.mcr[MCR_LOOP] && !i_bus.wr)
		|=> !o_line.txd && lsr[5])
		else $error("holding byte not launched");
	a_tx_idle_high: assert property (
		!st_r.busy |-> o_line.txd)
		else $error("line not idle between characters");
	a_rx_land: assert property (
		rx_valid |=> st_r.rx_full && lsr[0])
		else $error("received byte not flagged");
	a_rx_pop: assert property (
		(rd_hold && !rx_valid) |=> !lsr[0])
		else $error("receive byte still flagged after read");
	a_rx_halt: assert property (
		divisor_latch_select |=> !rx_valid)
		else $error("reception while divisor select set");
	a_iir_data: assert property (
		(i_bus.rd && i_bus.addr == OFF_IIR && st_r.rx_full && st_r.ier[IER_RX_AVAIL])
		|=> o_rdata == IIR_RX_DATA)
		else $error("identification misses waiting data");
	a_ier_read_zero: assert property (
		(i_bus.rd && i_bus.addr == OFF_IER && !divisor_latch_select) |=> o_rdata == 8'h00)
		else $error("offset 1 read not zero");

	// ------------------------------------------------------------
	// scenarios reached
	// ------------------------------------------------------------
	c_rx_byte: cover property (rx_valid ##[1:40] rd_hold);
	c_auto_tail: cover property ($fell(st_r.busy) && st_r.mcr[MCR_AUTO] ##[1:1000] $fell(st_r.drv));
	c_loop_byte: cover property (st_r.mcr[MCR_LOOP] && rx_valid);
	c_rs422_on: cover property (st_r.mcr[MCR_422] && o_line.drv_en);
	c_manual_queue: cover property (st_r.mcr[MCR_DIR] && !st_r.mcr[MCR_AUTO] && st_r.busy && st_r.thr_full);
endmodule : rdc_uart

/* File: sim/rdc_node.sv */
// remote serial node on the far end of the line: sends and captures frames
module rdc_node import rdc_pkg::*; (
	input  wire logic i_txd,
	input  wire logic i_drv_en,
	output logic      o_rxd
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// line stimulus
	// ------------------------------------------------------------
	// released pair idles high through fail-safe bias
	initial o_rxd = 1'b1;

	task automatic send(input logic [7:0] d, input int n, input real bt);
		o_rxd = 1'b0;
		#(bt);
		for (int i = 0; i < n; i++) begin
			o_rxd = d[i]; // lsb first
			#(bt);
		end
		o_rxd = 1'b1;
		#(bt);
	endtask : send

	// ------------------------------------------------------------
	// frame capture, mid-bit sampling
	// ------------------------------------------------------------
	// ok only if the far driver is on at the start and every stop is high
	task automatic recv(input int n, input int stops, input real bt,
			output logic [7:0] d, output logic ok);
		@(negedge i_txd);
		ok = i_drv_en;
		#(bt / 2.0);
		ok = ok & (i_txd === 1'b0);
		d = 8'h00;
		for (int i = 0; i < n; i++) begin
			#(bt);
			d[i] = i_txd;
		end
		for (int s = 0; s < stops; s++) begin
			#(bt);
			ok = ok & (i_txd === 1'b1);
		end
	endtask : recv
endmodule : rdc_node

/* File: sim/rdc_uart_tb.sv */
// self-checking bench for the rs485 uart with driver direction control
module rdc_uart_tb import rdc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int NF = 3;

	logic         clk;
	logic         rst_b;
	logic         ref_clk;
	rdc_bus_req_t bus;
	logic [7:0]   rdata;
	logic         rxd;
	rdc_line_t    line;
	int           num_errors = 0;
	int           checks = 0;
	int           len;
	int           stops;
	int           nb;
	int           falls;
	real          bt;
	logic [7:0]   got;
	logic [7:0]   d;
	logic         ok;
	logic [15:0]  f_div [NF] = '{16'h0001, 16'h0002, 16'h0001};
	logic [7:0]   f_lcr [NF] = '{8'h03, 8'h04, 8'h06};
	logic [7:0]   f_dat [NF] = '{8'hA5, 8'h13, 8'h5A};
	logic [7:0]   rst_exp [8] = '{8'h00, 8'h00, IIR_NONE, LCR_RST, MCR_RST, 8'h60, MSR_VALUE, 8'h00};

	rdc_uart i_rdc_uart (
		.i_clk     (clk),
		.i_rst_b   (rst_b),
		.i_bus     (bus),
		.o_rdata   (rdata),
		.i_ref_clk (ref_clk),
		.i_rxd     (rxd),
		.o_line    (line)
	);

	rdc_node i_rdc_node (
		.i_txd    (line.txd),
		.i_drv_en (line.drv_en),
		.o_rxd    (rxd)
	);

	always #50 clk = ~clk;
	always #271.267 ref_clk = ~ref_clk;
	always @(negedge line.txd) falls++;

	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(negedge clk);
		bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(negedge clk);
		bus = '0;
	endtask : wr

	// extra edge before sampling: safe for either reading of the latency
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(negedge clk);
		bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		bus = '0;
		@(negedge clk);
		v = rdata;
	endtask : rd

	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string what);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, g, e);
		end
	endtask : chk

	task automatic chk_rd(input logic [2:0] a, input logic [7:0] e, input string what);
		logic [7:0] v;
		rd(a, v);
		chk(v, e, what);
	endtask : chk_rd

	task automatic wait_lsr(input int b, input logic v);
		logic [7:0] s;
		int n;
		n = 0;
		s = 8'h00;
		do begin
			rd(OFF_LSR, s);
			n++;
		end while (s[b] !== v && n < 2000);
		chk(8'(n < 2000), 8'h01, "status wait");
	endtask : wait_lsr

	task automatic setup(input logic [15:0] div, input logic [7:0] lcr);
		wr(OFF_LCR, 8'h80);
		wr(OFF_HOLD, div[7:0]);
		wr(OFF_IER, div[15:8]);
		wr(OFF_LCR, lcr);
	endtask : setup

	// bit time follows from the reference through the divisor
	function automatic real bit_ns(input logic [15:0] div);
		return real'(div) * real'(OVS_FACTOR) * 1000.0 / REF_MHZ;
	endfunction : bit_ns

	task automatic test_done();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done

	initial begin
		#5000000;
		num_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		test_done();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		ref_clk = 1'b0;
		rst_b = 1'b0;
		bus = '0;
		falls = 0;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		chk(8'(line), 8'h08, "reset line");
		rd(OFF_HOLD, d);
		rd(OFF_HOLD, d);
		for (int a = 1; a < 8; a++) begin
			chk_rd(3'(a), rst_exp[a], "reset reg");
		end
		wr(OFF_LCR, 8'h80);
		chk_rd(OFF_HOLD, DIV_LO_RST, "div lo");
		chk_rd(OFF_IER, DIV_HI_RST, "div hi");
		wr(OFF_CONFIRM, 8'h5A);
		wr(OFF_LSR, 8'hFF);
		chk_rd(OFF_CONFIRM, 8'h5A, "offset 7");
		chk_rd(OFF_LSR, 8'h60, "status ro");
		// no reception while divisor select is set
		i_rdc_node.send(8'h66, 8, bit_ns(16'h000C));
		chk_rd(OFF_LSR, 8'h60, "divisor_latch_select rx");
		wr(OFF_LCR, 8'h03);
		// automatic direction, bit 1 also set to show it is ignored
		for (int k = 0; k < NF; k++) begin
			setup(f_div[k], f_lcr[k]);
			chk_rd(OFF_LCR, f_lcr[k], "line ctrl");
			wr(OFF_MCR, 8'h06);
			len = int'(f_lcr[k][1:0]) + 5;
			stops = int'(f_lcr[k][LCR_STOP]) + 1;
			nb = 1 + len + stops;
			bt = bit_ns(f_div[k]);
			fork
				i_rdc_node.recv(len, stops, bt, got, ok);
				begin
					wr(OFF_HOLD, f_dat[k]);
					@(negedge line.txd);
					#(2.0 * real'(nb) * bt - 1500.0);
					chk(8'(line.drv_en), 8'h01, "tail on");
					#(3000.0);
					chk(8'(line.drv_en), 8'h00, "tail off");
				end
			join
			chk(got, f_dat[k] & 8'((1 << len) - 1), "tx data");
			chk(8'(ok), 8'h01, "tx frame");
		end
		// manual direction, back-to-back bytes
		wr(OFF_MCR, 8'h02);
		chk(8'(line.drv_en), 8'h01, "manual on");
		fork
			begin
				i_rdc_node.recv(7, 2, bt, got, ok);
				chk(got, 8'h01, "byte one");
				i_rdc_node.recv(7, 2, bt, d, ok);
				chk(d, 8'h42, "byte two");
				chk(8'(ok), 8'h01, "manual frame");
			end
			begin
				wr(OFF_HOLD, 8'h81);
				wr(OFF_HOLD, 8'h42);
				chk_rd(OFF_LSR, 8'h00, "holding full");
				wait_lsr(6, 1'b1);
			end
		join
		wr(OFF_MCR, 8'h00);
		chk(8'(line.drv_en), 8'h00, "manual off");
		// own driver on: rs485 reception blanked
		wr(OFF_LCR, 8'h03);
		wr(OFF_MCR, 8'h02);
		i_rdc_node.send(8'h55, 8, bt);
		chk_rd(OFF_LSR, 8'h60, "echo blank");
		wr(OFF_MCR, 8'h00);
		// reception with interrupt identification
		wr(OFF_IER, 8'h01);
		i_rdc_node.send(8'h3C, 8, bt);
		wait_lsr(0, 1'b1);
		chk_rd(OFF_IIR, IIR_RX_DATA, "iir data");
		chk_rd(OFF_HOLD, 8'h3C, "rx byte");
		chk_rd(OFF_LSR, 8'h60, "rx empty");
		chk_rd(OFF_IIR, IIR_NONE, "iir none");
		// loopback, rs422, terminal ready
		wr(OFF_MCR, 8'hFF);
		chk_rd(OFF_MCR, 8'h1B, "mcr mask");
		falls = 0;
		wr(OFF_HOLD, 8'h77);
		wait_lsr(0, 1'b1);
		chk_rd(OFF_HOLD, 8'h77, "loop byte");
		chk(8'(falls), 8'h00, "loop quiet");
		chk(8'(line), 8'h0B, "loop line");
		wr(OFF_MCR, 8'h0C);
		chk_rd(OFF_MCR, 8'h08, "auto cleared");
		chk(8'(line), 8'h0D, "rs422 line");
		wr(OFF_MCR, 8'h01);
		chk(8'(line), 8'h0A, "dtr line");
		test_done();
	end
endmodule : rdc_uart_tb
